// File: inc/sncr_pkg.sv
/*
  Package for the switch node configuration register bank: register numbers,
  field positions, reset values and carrier structs.
  Assumes a single core clock domain and register numbers as word indexes.
*/
package sncr_pkg;
  // Register numbers
  localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
  localparam logic [7:0] REG_JTAG_IDENTIFICATION_WORD = 8'h09;
  localparam logic [7:0] REG_USER_CODE_WORD = 8'h0a;
  localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0c;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0d;
  localparam logic [7:0] REG_TILE0_DEBUG_LINE_CONFIG = 8'h10;
  localparam logic [7:0] REG_TILE1_DEBUG_LINE_CONFIG = 8'h11;
  localparam logic [7:0] REG_DEBUG_EVENT_SOURCE = 8'h1f;
  localparam logic [7:0] REG_LINK_STATUS_BASE = 8'h20;
  localparam int NUM_LINKS = 8;
  localparam int NUM_TILES = 2;
  // Reset values
  localparam logic [15:0] RST_SWITCH_CLOCK_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_REFERENCE_CLOCK_DIVIDER = 16'h0003;
  localparam logic [15:0] RST_NODE_IDENTIFIER = 16'h0000;
  localparam logic [31:0] RST_ROUTE_DIRECTIONS = 32'h0000_0000;
  // Field positions
  localparam int DBG_REQ_ENABLE_BIT = 1;
  localparam int DBG_DRIVE_ENABLE_BIT = 0;
  localparam int SRC_EXTERNAL_PIN_BIT = 4;
  localparam int SRC_CORE1_BIT = 1;
  localparam int SRC_CORE0_BIT = 0;
  localparam int LNK_TARGET_LSB = 24;
  localparam int LNK_DEST_LSB = 16;
  localparam int LNK_DIRECTION_LSB = 8;
  localparam int LNK_NETWORK_LSB = 4;
  localparam int LNK_JUNK_BIT = 2;
  localparam int LNK_DEST_BUSY_BIT = 1;
  localparam int LNK_SRC_BUSY_BIT = 0;
  localparam int USER_OTP_LSB = 18;
  // Link target kinds
  localparam logic [1:0] TARGET_SWITCH_LINK = 2'h0;
  localparam logic [1:0] TARGET_PROCESSOR_LINK = 2'h1;
  localparam logic [1:0] TARGET_SWITCH_CONTROL_PORT = 2'h2;
  localparam logic [1:0] TARGET_UNDEFINED = 2'h3;

  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] num;
    logic [31:0] wdata;
  } sncr_cfg_req_t;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } sncr_cfg_rsp_t;

  // Live status of one link from the switch fabric
  typedef struct packed {
    logic [1:0] target;
    logic [7:0] dest_link;
    logic junk;
    logic dest_busy;
    logic src_busy;
  } sncr_link_stat_t;

  // Routing lookup answer
  typedef struct packed {
    logic valid;
    logic local_hit;
    logic [3:0] direction;
  } sncr_route_t;

  typedef enum logic [1:0] {
    SNCR_IDLE = 2'b01,
    SNCR_ANSWER = 2'b10
  } sncr_state_t;
endpackage

// File: rtl/sncr_regs.sv
/*
  Node configuration register bank of the on-chip packet switch, with the
  routing direction lookup and the debug line logic.
  Assumes requests, link status and debug inputs are synchronous to core_clk.
*/
`timescale 1ns/1ns
// Summary of operation
// - Switch clock divider: 16-bit RW low field, reset zero, upper bits read zero.
// - Reference clock divider: 16-bit RW low field, resets to three.
// - User code word read-only: OTP code in 31:18, metal ID in 17:0.
// - Low direction table: eight 4-bit RW entries for mismatch bits 0..7.
// - High direction table: eight 4-bit RW entries for mismatch bits 8..15.
// - Route by table entry of highest differing bit of destination versus node id.
// - Debug config bit 1 lets the shared debug line request core debug.
// - Debug config bit 0 lets the core in-debug flag drive the shared line.
// - Debug source records last event cause: pin bit 4, core1 bit 1, core0 bit 0.
// - Link status 25:24 reports the link target type, read-only.
// - Link status 23:16 reports destination link while in use, read-only.
// - Link status 11:8 holds RW direction field, reset zero.
// - Link status 5:4 holds RW network number, reset zero.
// - Link status bit 2 shows the current packet is junk.
// - Link status bit 1 dest side busy, bit 0 source side busy.
// - Link registers are numbers 0x20 onward, one per link 0..7.
// - JTAG identification word read-only, fields 31:28, 27:12, 11:1, 0.
// - Node identifier is 16-bit RW, reset zero.
module sncr_regs import sncr_pkg::*; #(
  parameter logic [31:0] JTAG_ID_VALUE = 32'h1000_0001, // Arbitrary value
  parameter logic [13:0] USER_OTP_VALUE = 14'h0000,
  parameter logic [17:0] METAL_ID_VALUE = 18'h00001 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Configuration access
  input wire sncr_cfg_req_t cfg_req,
  output sncr_cfg_rsp_t cfg_rsp,
  // Routing lookup
  input wire logic route_req,
  input wire logic [15:0] route_dest_id,
  output sncr_route_t route_rsp,
  // Link status from the fabric
  input wire sncr_link_stat_t [NUM_LINKS-1:0] link_stat,
  // Debug
  input wire logic [NUM_TILES-1:0] core_in_debug_flag,
  input wire logic ext_debug_pin,
  output logic shared_debug_line,
  output logic [NUM_TILES-1:0] core_debug_request,
  // Configuration fields steering the fabric
  output logic [15:0] switch_clock_divider,
  output logic [15:0] reference_clock_divider,
  output logic [15:0] node_identifier,
  output logic [NUM_LINKS*4-1:0] link_direction,
  output logic [NUM_LINKS*2-1:0] link_network
);

  typedef struct packed {
    sncr_state_t state;
    sncr_cfg_rsp_t rsp;
    sncr_route_t route;
    logic [15:0] swdiv;
    logic [15:0] refdiv;
    logic [15:0] node_id;
    logic [31:0] dir_lo;
    logic [31:0] dir_hi;
    logic [NUM_TILES-1:0] dbg_req_en;
    logic [NUM_TILES-1:0] dbg_drv_en;
    logic [2:0] dbg_src;
    logic line;
    logic [NUM_TILES-1:0] dbg_request;
    logic [NUM_LINKS*4-1:0] ldir;
    logic [NUM_LINKS*2-1:0] lnet;
  } sncr_st_t;

  sncr_st_t st;
  sncr_st_t next_st;
  logic [31:0] link_word [NUM_LINKS];
  logic [NUM_LINKS-1:0] link_hit;
  logic [NUM_TILES-1:0] core_drive;
  logic [NUM_TILES-1:0] tile_hit;

  // Per-link status word and address match
  for (genvar k = 0; k < NUM_LINKS; k++) begin : g_link
    always_comb begin
      link_word[k] = '0;
      link_word[k][LNK_TARGET_LSB +: 2] = link_stat[k].target;
      link_word[k][LNK_DEST_LSB +: 8] = (link_stat[k].src_busy | link_stat[k].dest_busy) ?
        link_stat[k].dest_link : 8'h00;
      link_word[k][LNK_DIRECTION_LSB +: 4] = st.ldir[k*4 +: 4];
      link_word[k][LNK_NETWORK_LSB +: 2] = st.lnet[k*2 +: 2];
      link_word[k][LNK_JUNK_BIT] = link_stat[k].junk;
      link_word[k][LNK_DEST_BUSY_BIT] = link_stat[k].dest_busy;
      link_word[k][LNK_SRC_BUSY_BIT] = link_stat[k].src_busy;
    end
    assign link_hit[k] = (cfg_req.num == REG_LINK_STATUS_BASE + 8'(k));
  end

  // Per-tile debug line terms
  for (genvar t = 0; t < NUM_TILES; t++) begin : g_tile
    assign core_drive[t] = st.dbg_drv_en[t] & core_in_debug_flag[t];
    assign tile_hit[t] = (cfg_req.num == REG_TILE0_DEBUG_LINE_CONFIG + 8'(t));
  end

  // Next-state logic: writes, reads, routing and debug line
  always_comb begin
    logic [15:0] diff;
    logic [3:0] msb;
    logic [31:0] rd;
    logic line_now;
    diff = '0;
    msb = '0;
    rd = '0;
    line_now = 1'b0;
    next_st = st;
    // Writes; read-only fields and unmapped numbers ignore them
    if (cfg_req.wr) begin
      case (cfg_req.num)
        REG_SWITCH_CLOCK_DIVIDER: next_st.swdiv = cfg_req.wdata[15:0];
        REG_REFERENCE_CLOCK_DIVIDER: next_st.refdiv = cfg_req.wdata[15:0];
        REG_NODE_IDENTIFIER: next_st.node_id = cfg_req.wdata[15:0];
        REG_ROUTE_DIRECTIONS_LOW: next_st.dir_lo = cfg_req.wdata;
        REG_ROUTE_DIRECTIONS_HIGH: next_st.dir_hi = cfg_req.wdata;
        REG_DEBUG_EVENT_SOURCE: next_st.dbg_src = {cfg_req.wdata[SRC_EXTERNAL_PIN_BIT],
          cfg_req.wdata[SRC_CORE1_BIT], cfg_req.wdata[SRC_CORE0_BIT]};
        default: begin
        end
      endcase
      for (int t = 0; t < NUM_TILES; t++) begin
        if (tile_hit[t]) begin
          next_st.dbg_req_en[t] = cfg_req.wdata[DBG_REQ_ENABLE_BIT];
          next_st.dbg_drv_en[t] = cfg_req.wdata[DBG_DRIVE_ENABLE_BIT];
        end
      end
      for (int k = 0; k < NUM_LINKS; k++) begin
        if (link_hit[k]) begin
          next_st.ldir[k*4 +: 4] = cfg_req.wdata[LNK_DIRECTION_LSB +: 4];
          next_st.lnet[k*2 +: 2] = cfg_req.wdata[LNK_NETWORK_LSB +: 2];
        end
      end
    end
    // Shared line: pin or any enabled core in debug
    line_now = ext_debug_pin | (|core_drive);
    next_st.line = line_now;
    next_st.dbg_request = st.dbg_req_en & {NUM_TILES{line_now}};
    // Record the cause on a rising edge; a hardware event wins over a write
    if (line_now && !st.line) begin
      next_st.dbg_src = {ext_debug_pin, core_drive[1], core_drive[0]};
    end
    // Read mux; reserved bits read zero
    case (cfg_req.num)
      REG_SWITCH_CLOCK_DIVIDER: rd = {16'h0000, st.swdiv};
      REG_REFERENCE_CLOCK_DIVIDER: rd = {16'h0000, st.refdiv};
      REG_JTAG_IDENTIFICATION_WORD: rd = JTAG_ID_VALUE;
      REG_USER_CODE_WORD: rd = {USER_OTP_VALUE, METAL_ID_VALUE};
      REG_NODE_IDENTIFIER: rd = {16'h0000, st.node_id};
      REG_ROUTE_DIRECTIONS_LOW: rd = st.dir_lo;
      REG_ROUTE_DIRECTIONS_HIGH: rd = st.dir_hi;
      REG_DEBUG_EVENT_SOURCE: rd = {27'h0000000, st.dbg_src[2], 2'h0, st.dbg_src[1:0]};
      default: rd = '0;
    endcase
    for (int t = 0; t < NUM_TILES; t++) begin
      if (tile_hit[t]) begin
        rd = {30'h0, st.dbg_req_en[t], st.dbg_drv_en[t]};
      end
    end
    for (int k = 0; k < NUM_LINKS; k++) begin
      if (link_hit[k]) begin
        rd = link_word[k];
      end
    end
    // One-cycle read answer
    case (st.state)
      SNCR_IDLE: begin
        next_st.rsp.valid = cfg_req.rd;
        next_st.rsp.rdata = cfg_req.rd ? rd : st.rsp.rdata;
        next_st.state = cfg_req.rd ? SNCR_ANSWER : SNCR_IDLE;
      end
      SNCR_ANSWER: begin
        next_st.rsp.valid = cfg_req.rd;
        next_st.rsp.rdata = cfg_req.rd ? rd : st.rsp.rdata;
        next_st.state = cfg_req.rd ? SNCR_ANSWER : SNCR_IDLE;
      end
      default: begin
        next_st.state = SNCR_IDLE;
        next_st.rsp.valid = 1'b0;
      end
    endcase
    // Route lookup: highest differing bit picks the table entry
    diff = route_dest_id ^ st.node_id;
    for (int b = 0; b < 16; b++) begin
      if (diff[b]) begin
        msb = 4'(b);
      end
    end
    next_st.route.valid = route_req;
    next_st.route.local_hit = (diff == 16'h0000);
    if (diff == 16'h0000) begin
      next_st.route.direction = 4'h0;
    end else if (msb[3]) begin
      next_st.route.direction = st.dir_hi[msb[2:0]*4 +: 4];
    end else begin
      next_st.route.direction = st.dir_lo[msb[2:0]*4 +: 4];
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.state <= SNCR_IDLE;
      st.swdiv <= RST_SWITCH_CLOCK_DIVIDER;
      st.refdiv <= RST_REFERENCE_CLOCK_DIVIDER;
      st.node_id <= RST_NODE_IDENTIFIER;
      st.dir_lo <= RST_ROUTE_DIRECTIONS;
      st.dir_hi <= RST_ROUTE_DIRECTIONS;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign cfg_rsp = st.rsp;
  assign route_rsp = st.route;
  assign shared_debug_line = st.line;
  assign core_debug_request = st.dbg_request;
  assign switch_clock_divider = st.swdiv;
  assign reference_clock_divider = st.refdiv;
  assign node_identifier = st.node_id;
  assign link_direction = st.ldir;
  assign link_network = st.lnet;

  // Checks
  property p_refdiv_write;
    @(posedge core_clk) disable iff (!arst_n)
      cfg_req.wr && cfg_req.num == REG_REFERENCE_CLOCK_DIVIDER |=> reference_clock_divider == $past(cfg_req.wdata[15:0]);
  endproperty
  a_refdiv_write: assert property (p_refdiv_write) else $error("ref divider write lost");
  property p_swdiv_read;
    @(posedge core_clk) disable iff (!arst_n)
      cfg_req.rd && cfg_req.num == REG_SWITCH_CLOCK_DIVIDER |=> cfg_rsp.valid && cfg_rsp.rdata[31:16] == 16'h0000
        && cfg_rsp.rdata[15:0] == $past(switch_clock_divider);
  endproperty
  a_swdiv_read: assert property (p_swdiv_read) else $error("switch divider read wrong");
  property p_usercode;
    @(posedge core_clk) disable iff (!arst_n)
      cfg_req.rd && cfg_req.num == REG_USER_CODE_WORD |=> cfg_rsp.rdata == {USER_OTP_VALUE, METAL_ID_VALUE};
  endproperty
  a_usercode: assert property (p_usercode) else $error("user code wrong");
  property p_local;
    @(posedge core_clk) disable iff (!arst_n)
      route_req && route_dest_id == node_identifier |=> route_rsp.valid && route_rsp.local_hit;
  endproperty
  a_local: assert property (p_local) else $error("local delivery missed");
  property p_route_top;
    @(posedge core_clk) disable iff (!arst_n)
      route_req && (route_dest_id[15] != node_identifier[15]) |=> route_rsp.direction == $past(st.dir_hi[31:28]);
  endproperty
  a_route_top: assert property (p_route_top) else $error("route top dimension wrong");
  property p_dbg_req;
    @(posedge core_clk) disable iff (!arst_n)
      !st.dbg_req_en[0] |=> !core_debug_request[0];
  endproperty
  a_dbg_req: assert property (p_dbg_req) else $error("debug request without enable");
  property p_dbg_drive;
    @(posedge core_clk) disable iff (!arst_n)
      st.dbg_drv_en[1] && core_in_debug_flag[1] |=> shared_debug_line;
  endproperty
  a_dbg_drive: assert property (p_dbg_drive) else $error("core did not drive debug line");
  property p_link_stat;
    @(posedge core_clk) disable iff (!arst_n)
      cfg_req.rd && cfg_req.num == REG_LINK_STATUS_BASE |=> cfg_rsp.rdata[25:24] == $past(link_stat[0].target)
        && cfg_rsp.rdata[2:0] == $past({link_stat[0].junk, link_stat[0].dest_busy, link_stat[0].src_busy});
  endproperty
  a_link_stat: assert property (p_link_stat) else $error("link status read wrong");
  c_route: cover property (@(posedge core_clk) route_rsp.valid && !route_rsp.local_hit);
  c_dbg: cover property (@(posedge core_clk) shared_debug_line && core_debug_request[0]);
  c_link_rd: cover property (@(posedge core_clk) cfg_rsp.valid && cfg_rsp.rdata[0]);
endmodule

// File: dv/sncr_fabric_model.sv
/*
  Far-side model: switch fabric link status and processor core debug flags.
  Assumes the bench steers busy links and debug flags in step with core_clk.
*/
`timescale 1ns/1ns
module sncr_fabric_model import sncr_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Steering from the bench
  input wire logic [NUM_LINKS-1:0] busy_mask,
  input wire logic [NUM_TILES-1:0] dbg_cmd,
  input wire logic pin_cmd,
  // Toward the register bank
  output sncr_link_stat_t [NUM_LINKS-1:0] link_stat,
  output logic [NUM_TILES-1:0] core_in_debug_flag,
  output logic ext_debug_pin
);
  logic [7:0] churn = 8'h00;

  // Idle dest field churns, so a bank that forgets to mask it reads garbage
  always_ff @(posedge core_clk) begin
    churn <= churn + 8'h5b;
  end

  // Each link shows its own target kind; odd links busy by default
  always_comb begin
    for (int i = 0; i < NUM_LINKS; i++) begin
      link_stat[i].target = 2'(i);
      link_stat[i].dest_link = busy_mask[i] ? 8'(i) + 8'h40 : churn;
      link_stat[i].junk = busy_mask[i] & i[0];
      link_stat[i].dest_busy = busy_mask[i];
      link_stat[i].src_busy = busy_mask[i] & i[1];
    end
  end

  // Debug flags and the external pin follow the bench directly
  assign core_in_debug_flag = dbg_cmd;
  assign ext_debug_pin = pin_cmd;
endmodule

// File: dv/sncr_regs_tb_top.sv
/*
  Self-checking bench for the node configuration register bank.
  Assumes the fabric model on the link side and a 25 MHz core clock.
*/
`timescale 1ns/1ns
module sncr_regs_tb_top import sncr_pkg::*; ();
  typedef struct packed {logic wr; logic [7:0] num; logic [31:0] wd; logic [31:0] ex;} sncr_row_t;
  localparam logic [31:0] JTAG_V = 32'h2000_0003; // Arbitrary value
  localparam logic [31:0] USER_V = {14'h0005, 18'h00007}; // Arbitrary value
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic route_req = 1'b0;
  logic pin_cmd = 1'b0;
  logic [15:0] route_dest_id = 16'h0000;
  logic [NUM_LINKS-1:0] busy_mask = 8'haa;
  logic [NUM_TILES-1:0] dbg_cmd = 2'b00;
  sncr_cfg_req_t cfg_req = '0;
  sncr_cfg_rsp_t cfg_rsp;
  sncr_route_t route_rsp;
  sncr_link_stat_t [NUM_LINKS-1:0] link_stat;
  logic [NUM_TILES-1:0] core_in_debug_flag, core_debug_request;
  logic ext_debug_pin, shared_debug_line;
  logic [15:0] scd, rcd, nid, lnet;
  logic [31:0] ldir, rd_val;
  int error_cnt = 0;
  int total_checks = 0;
  // Reset values, read-only words, reserved bits and an unmapped number
  sncr_row_t rows [21] = '{
    '{1'b0, 8'h07, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h3}, '{1'b0, 8'h05, 32'h0, 32'h0},
    '{1'b0, 8'h0c, 32'h0, 32'h0}, '{1'b0, 8'h0d, 32'h0, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h0},
    '{1'b0, 8'h11, 32'h0, 32'h0}, '{1'b0, 8'h1f, 32'h0, 32'h0}, '{1'b0, 8'h09, 32'h0, JTAG_V},
    '{1'b0, 8'h0a, 32'h0, USER_V}, '{1'b1, 8'h07, 32'hffff_ffff, 32'h0000_ffff},
    '{1'b1, 8'h08, 32'hffff_ffff, 32'h0000_ffff}, '{1'b1, 8'h09, 32'h0, JTAG_V},
    '{1'b1, 8'h0a, 32'h0, USER_V}, '{1'b1, 8'h05, 32'hffff_0012, 32'h0000_0012},
    '{1'b1, 8'h0c, 32'h7654_3210, 32'h7654_3210}, '{1'b1, 8'h0d, 32'hfedc_ba98, 32'hfedc_ba98},
    '{1'b1, 8'h10, 32'hffff_fffc, 32'h0}, '{1'b1, 8'h28, 32'hffff_ffff, 32'h0},
    '{1'b1, 8'h11, 32'h0000_0003, 32'h3}, '{1'b1, 8'h1f, 32'hffff_ffff, 32'h13}};

  always #20 core_clk = ~core_clk;

  sncr_regs #(.JTAG_ID_VALUE(JTAG_V), .USER_OTP_VALUE(14'h0005), .METAL_ID_VALUE(18'h00007)) u_sncr_regs (
    .core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .route_req(route_req), .route_dest_id(route_dest_id), .route_rsp(route_rsp),
    .link_stat(link_stat), .core_in_debug_flag(core_in_debug_flag), .ext_debug_pin(ext_debug_pin),
    .shared_debug_line(shared_debug_line), .core_debug_request(core_debug_request),
    .switch_clock_divider(scd), .reference_clock_divider(rcd), .node_identifier(nid),
    .link_direction(ldir), .link_network(lnet));

  sncr_fabric_model u_sncr_fabric_model (
    .core_clk(core_clk), .busy_mask(busy_mask), .dbg_cmd(dbg_cmd), .pin_cmd(pin_cmd),
    .link_stat(link_stat), .core_in_debug_flag(core_in_debug_flag), .ext_debug_pin(ext_debug_pin));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Write strobe stands for exactly one edge
  task automatic cfg_wr(input logic [7:0] num, input logic [31:0] wd);
    @(posedge core_clk);
    cfg_req <= '{rd: 1'b0, wr: 1'b1, num: num, wdata: wd};
    @(posedge core_clk);
    cfg_req.wr <= 1'b0;
  endtask

  // Read answer is a one-cycle valid pulse; a missing answer ends the run
  task automatic cfg_rd(input logic [7:0] num, output logic [31:0] q);
    @(posedge core_clk);
    cfg_req <= '{rd: 1'b1, wr: 1'b0, num: num, wdata: 32'h0};
    @(posedge core_clk);
    cfg_req.rd <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (cfg_rsp.valid === 1'b1) begin
        q = cfg_rsp.rdata;
        return;
      end
      @(posedge core_clk);
    end
    error_cnt++;
    final_report();
  endtask

  // Local hits are judged on the flags only; the direction is then unused
  task automatic route(input logic [15:0] dest, input logic loc, input logic [3:0] dir);
    @(posedge core_clk);
    route_req <= 1'b1;
    route_dest_id <= dest;
    @(posedge core_clk);
    route_req <= 1'b0;
    #1;
    chk(loc ? 32'(route_rsp[5:4]) : 32'(route_rsp), loc ? 32'h3 : {26'h0, 2'b10, dir});
  endtask

  function automatic logic [31:0] link_exp(input int i, input logic b);
    link_exp = {6'h0, 2'(i), b ? 8'(i) + 8'h40 : 8'h00, 8'h0f, 4'h3, 1'b0, b & i[0], b, b & i[1]};
  endfunction

  initial begin
    repeat (6) @(posedge core_clk);
    chk(32'(rcd), 32'h3);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        cfg_wr(rows[i].num, rows[i].wd);
      end
      cfg_rd(rows[i].num, rd_val);
      chk(rd_val, rows[i].ex);
    end
    chk({scd, rcd}, 32'hffff_ffff);
    chk(32'(nid), 32'h12);
    // Node id is 0x0012; the highest differing bit picks the entry
    route(16'h0002, 1'b0, 4'h4);
    route(16'h0092, 1'b0, 4'h7);
    route(16'h0013, 1'b0, 4'h0);
    route(16'h0112, 1'b0, 4'h8);
    route(16'h0a12, 1'b0, 4'hb);
    route(16'hc012, 1'b0, 4'hf);
    route(16'h0012, 1'b1, 4'h0);
    // Link words: all bits written, only direction and network stick
    for (int i = 0; i < NUM_LINKS; i++) begin
      cfg_wr(REG_LINK_STATUS_BASE + 8'(i), 32'hffff_ffff);
    end
    for (int i = 0; i < NUM_LINKS; i++) begin
      cfg_rd(REG_LINK_STATUS_BASE + 8'(i), rd_val);
      chk(rd_val, link_exp(i, busy_mask[i]));
    end
    chk(ldir, 32'hffff_ffff);
    chk(32'(lnet), 32'hffff);
    // Tile 0 may drive the line, tile 1 may be requested by it
    cfg_wr(8'h10, 32'h1);
    cfg_wr(8'h11, 32'h2);
    @(posedge core_clk);
    dbg_cmd <= 2'b01;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'({shared_debug_line, core_debug_request}), 32'h6);
    cfg_rd(8'h1f, rd_val);
    chk(rd_val, 32'h1);
    @(posedge core_clk);
    dbg_cmd <= 2'b10;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'({shared_debug_line, core_debug_request}), 32'h0);
    @(posedge core_clk);
    pin_cmd <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'({shared_debug_line, core_debug_request}), 32'h6);
    cfg_rd(8'h1f, rd_val);
    chk(rd_val, 32'h10);
    // Pin quiet, then core 1 gets its drive enable: the line rises again from core 1
    @(posedge core_clk);
    pin_cmd <= 1'b0;
    cfg_wr(8'h11, 32'h3);
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'({shared_debug_line, core_debug_request}), 32'h6);
    cfg_rd(8'h1f, rd_val);
    chk(rd_val, 32'h2);
    // Second reset in mid-run brings the fields back
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({scd, rcd}, 32'h0000_0003);
    chk(ldir, 32'h0);
    chk(32'(lnet), 32'h0);
    // Release again; the first read after it must see reset contents
    @(posedge core_clk);
    arst_n <= 1'b1;
    cfg_rd(8'h05, rd_val);
    chk(rd_val, 32'h0);
    cfg_rd(8'h1f, rd_val);
    chk(rd_val, 32'h0);
    final_report();
  end
endmodule
